// ---- src/light_sensor_status_irq.sv ----
// Behaviour
// - Overload flag set when conversion exceeded full scale, else cleared, each measurement.
// - Manual range may flag overload though result is below full scale.
// - Auto mode overload below max range: abort, step range up, restart.
// - Escalation repeats to no overload or max range; flag updated at end.
// - Conversion-complete flag set when each conversion finishes.
// - Complete flag cleared by config read or non-shutdown config write.
// - Config write selecting shutdown leaves complete flag unchanged.
// - Above flag set after enough consecutive results over high threshold.
// - Below flag set after enough consecutive results under low threshold.
// - Transparent style: alert and limit flags follow comparison directly.
// - Latched style: alert and limit flags hold until software clears them.
// - Sense bit 0: alert drives pin low.
// - Sense bit 1: alert releases pin, pin otherwise held low.
// - Masking affects only result read; comparisons use true result.
// - Fault count field 00,01,10,11 needs 1,2,4,8 consecutive faults.
// - Range select 1100b selects automatic full-scale range.
// - Entering shutdown keeps complete flag, limit flags and alert pin.
// - Result and thresholds compared on common lux scale.
`timescale 1ns/1ps
`default_nettype none

module light_sensor_status_irq (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Configuration register access from the serial front end
    input wire logic cfg_wr_i,
    input wire logic [15:0] cfg_wdata_i,
    input wire logic cfg_rd_i,
    output logic [15:0] cfg_rdata_o,
    // Measurement from the converter
    input wire light_sensor_pkg::meas_s meas_i,
    // Limit registers
    input wire logic [15:0] low_limit_i,
    input wire logic [15:0] high_limit_i,
    // Converter control
    output logic conv_run_o,
    output logic conv_long_o,
    output logic [3:0] conv_range_o,
    output logic conv_restart_o,
    // Result register read value
    output logic [15:0] result_o,
    // Open-drain alert pin
    output logic alert_o,
    output logic alert_oe_b_o
);

    light_sensor_pkg::state_s s_q;
    light_sensor_pkg::state_s s_d;

    // Value in lux steps: mantissa shifted by exponent
    function automatic logic [26:0] lux(input logic [15:0] w);
        lux = {15'h0000, w[11:0]} << w[15:12];
    endfunction

    // Next counter value, saturating, cleared when no fault
    function automatic logic [3:0] bump(input logic [3:0] c, input logic fault);
        if (!fault) begin
            bump = light_sensor_pkg::COUNT_RST;
        end else if (c >= light_sensor_pkg::COUNT_MAX) begin
            bump = c;
        end else begin
            bump = c + 4'h1;
        end
    endfunction

    logic is_auto;
    logic hi_fault;
    logic lo_fault;
    logic hi_met;
    logic lo_met;
    logic active;
    logic [3:0] need;
    logic [15:0] true_result;
    light_sensor_pkg::cfg_s wcfg;

    // Measurement decode and comparison
    always_comb begin
        is_auto = (s_q.cfg.range_select == light_sensor_pkg::RANGE_AUTO);
        true_result = {s_q.range, meas_i.mantissa};
        hi_fault = lux(true_result) > lux(high_limit_i);
        lo_fault = lux(true_result) < lux(low_limit_i);
        need = 4'h1 << s_q.cfg.fault_count;
        wcfg = light_sensor_pkg::cfg_s'(cfg_wdata_i);
    end

    // Next state
    always_comb begin
        s_d = s_q;
        s_d.restart = 1'b0;
        hi_met = 1'b0;
        lo_met = 1'b0;
        // Software access: writable fields and clearing actions
        if (cfg_wr_i) begin
            s_d.cfg.range_select = wcfg.range_select;
            s_d.cfg.conv_time = wcfg.conv_time;
            s_d.cfg.mode = wcfg.mode;
            s_d.cfg.latch = wcfg.latch;
            s_d.cfg.alert_sense = wcfg.alert_sense;
            s_d.cfg.zero_scaling_out = wcfg.zero_scaling_out;
            s_d.cfg.fault_count = wcfg.fault_count;
            if (wcfg.mode != light_sensor_pkg::MODE_SHUTDOWN) begin
                s_d.cfg.sample_done = 1'b0;
            end
        end
        if (cfg_rd_i) begin
            s_d.cfg.sample_done = 1'b0;
            if (s_q.cfg.latch) begin
                s_d.cfg.above_mark = 1'b0;
                s_d.cfg.below_mark = 1'b0;
            end
        end
        // Measurement events win over clears
        if (meas_i.done && s_q.cfg.mode != light_sensor_pkg::MODE_SHUTDOWN) begin
            if (is_auto && meas_i.overload && s_q.range < light_sensor_pkg::RANGE_MAX) begin
                s_d.range = s_q.range + 4'h1;
                s_d.restart = 1'b1;
            end else begin
                s_d.cfg.range_overload = meas_i.overload;
                s_d.cfg.sample_done = 1'b1;
                s_d.result = true_result;
                s_d.hi_cnt = bump(s_q.hi_cnt, hi_fault);
                s_d.lo_cnt = bump(s_q.lo_cnt, lo_fault);
                hi_met = s_d.hi_cnt >= need;
                lo_met = s_d.lo_cnt >= need;
                if (s_q.cfg.latch) begin
                    s_d.cfg.above_mark = s_q.cfg.above_mark | hi_met;
                    s_d.cfg.below_mark = s_q.cfg.below_mark | lo_met;
                end else begin
                    s_d.cfg.above_mark = hi_met;
                    s_d.cfg.below_mark = lo_met;
                end
                if (s_q.cfg.mode == light_sensor_pkg::MODE_SINGLE && !cfg_wr_i) begin
                    s_d.cfg.mode = light_sensor_pkg::MODE_SHUTDOWN;
                end
                if (is_auto) begin
                    s_d.range = light_sensor_pkg::RANGE_LOW;
                end
            end
        end
        // Manual range drives the converter directly
        if (s_d.cfg.range_select != light_sensor_pkg::RANGE_AUTO) begin
            s_d.range = s_d.cfg.range_select;
        end else if (is_auto == 1'b0) begin
            s_d.range = light_sensor_pkg::RANGE_LOW;
        end
        // Alert pin follows the flags; sense picks drive or release
        active = s_d.cfg.above_mark | s_d.cfg.below_mark;
        s_d.alert_oe_b = s_d.cfg.alert_sense ? active : ~active;
        s_d.rdata = s_d.cfg;
        if (s_d.cfg.zero_scaling_out
            && s_d.cfg.range_select < light_sensor_pkg::RANGE_AUTO) begin
            s_d.result_out = {4'h0, s_d.result[11:0]};
        end else begin
            s_d.result_out = s_d.result;
        end
    end

    // State register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_q.cfg <= '{range_select: light_sensor_pkg::RANGE_RST,
                         conv_time: light_sensor_pkg::CONV_TIME_RST,
                         mode: light_sensor_pkg::MODE_RST,
                         range_overload: 1'b0,
                         sample_done: 1'b0,
                         above_mark: 1'b0,
                         below_mark: 1'b0,
                         latch: light_sensor_pkg::LATCH_RST,
                         alert_sense: light_sensor_pkg::SENSE_RST,
                         zero_scaling_out: light_sensor_pkg::ZERO_RST,
                         fault_count: light_sensor_pkg::FAULT_RST};
            s_q.range <= light_sensor_pkg::RANGE_LOW;
            s_q.hi_cnt <= light_sensor_pkg::COUNT_RST;
            s_q.lo_cnt <= light_sensor_pkg::COUNT_RST;
            s_q.restart <= 1'b0;
            s_q.alert_oe_b <= 1'b1;
            s_q.result <= light_sensor_pkg::WORD_RST;
            s_q.rdata <= light_sensor_pkg::WORD_RST;
            s_q.result_out <= light_sensor_pkg::WORD_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs
    assign cfg_rdata_o = s_q.rdata;
    assign conv_run_o = (s_q.cfg.mode != light_sensor_pkg::MODE_SHUTDOWN);
    assign conv_long_o = s_q.cfg.conv_time;
    assign conv_range_o = s_q.range;
    assign conv_restart_o = s_q.restart;
    assign result_o = s_q.result_out;
    assign alert_o = 1'b0; // Open drain: only ever pulls low
    assign alert_oe_b_o = s_q.alert_oe_b;

endmodule

`default_nettype wire

// ---- include/light_sensor_pkg.sv ----
package light_sensor_pkg;

    // Range codes
    localparam logic [3:0] RANGE_AUTO = 4'hc;
    localparam logic [3:0] RANGE_MAX = 4'hb;
    localparam logic [3:0] RANGE_LOW = 4'h0;

    // Operating-mode codes
    localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
    localparam logic [1:0] MODE_SINGLE = 2'h1;

    // Configuration field positions
    localparam int RANGE_POS = 12;
    localparam int CONV_TIME_POS = 11;
    localparam int MODE_POS = 9;
    localparam int OVERLOAD_POS = 8;
    localparam int DONE_POS = 7;
    localparam int ABOVE_POS = 6;
    localparam int BELOW_POS = 5;
    localparam int LATCH_POS = 4;
    localparam int SENSE_POS = 3;
    localparam int ZERO_POS = 2;
    localparam int FAULT_POS = 0;

    // Values after reset
    localparam logic [3:0] RANGE_RST = 4'hc;
    localparam logic CONV_TIME_RST = 1'b1;
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic LATCH_RST = 1'b1;
    localparam logic SENSE_RST = 1'b0;
    localparam logic ZERO_RST = 1'b0;
    localparam logic [1:0] FAULT_RST = 2'h0;
    localparam logic [3:0] COUNT_RST = 4'h0;
    localparam logic [15:0] WORD_RST = 16'h0000;

    // Saturation point of the consecutive-fault counters
    localparam logic [3:0] COUNT_MAX = 4'h8;

    // Configuration register, bit 15 first
    typedef struct packed {
        logic [3:0] range_select;
        logic conv_time;
        logic [1:0] mode;
        logic range_overload;
        logic sample_done;
        logic above_mark;
        logic below_mark;
        logic latch;
        logic alert_sense;
        logic zero_scaling_out;
        logic [1:0] fault_count;
    } cfg_s;

    // Finished measurement from the converter
    typedef struct packed {
        logic done;
        logic overload;
        logic [11:0] mantissa;
    } meas_s;

    // Whole state of the status block
    typedef struct packed {
        cfg_s cfg;
        logic [3:0] range;
        logic [3:0] hi_cnt;
        logic [3:0] lo_cnt;
        logic restart;
        logic alert_oe_b;
        logic [15:0] result;
        logic [15:0] rdata;
        logic [15:0] result_out;
    } state_s;

endpackage

// ---- test/light_converter_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module light_converter_model (
    // Clock and bench commands
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic spike_i,
    input wire logic [22:0] lux_i,
    // Range in use and finished measurement
    input wire logic [3:0] range_i,
    output var light_sensor_pkg::meas_s meas_o
);
    // One conversion per go pulse; stale mantissa scrambled
    always_ff @(posedge clk_i) begin
        meas_o.done <= go_i;
        meas_o.overload <= spike_i || (lux_i >> range_i) > 23'h000fff;
        meas_o.mantissa <= go_i ? 12'(lux_i >> range_i) : ~meas_o.mantissa;
    end
endmodule
`default_nettype wire

// ---- test/light_sensor_status_irq_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module light_sensor_status_irq_props (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Inputs of the block
    input wire logic cfg_wr_i,
    input wire logic [15:0] cfg_wdata_i,
    input wire logic cfg_rd_i,
    input wire light_sensor_pkg::meas_s meas_i,
    input wire logic [15:0] high_limit_i,
    // Outputs of the block
    input wire logic [15:0] cfg_rdata_o,
    input wire logic conv_run_o,
    input wire logic [3:0] conv_range_o,
    input wire logic conv_restart_o,
    input wire logic [15:0] result_o,
    input wire logic alert_oe_b_o
);
    logic taken, esc, fin, quiet, hi_hit, shut;
    // Measurement classes and true-scale comparison
    assign taken = meas_i.done && conv_run_o;
    assign esc = taken && meas_i.overload && cfg_rdata_o[15:12] == 4'hc && conv_range_o < 4'hb;
    assign fin = taken && !esc;
    assign quiet = !cfg_wr_i && !cfg_rd_i;
    assign shut = cfg_wdata_i[10:9] == light_sensor_pkg::MODE_SHUTDOWN;
    assign hi_hit = ({15'h0, meas_i.mantissa} << conv_range_o) >
        ({15'h0, high_limit_i[11:0]} << high_limit_i[15:12]);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // Escalation step seen one cycle later
    sequence s_step_up;
        conv_restart_o && conv_range_o == $past(conv_range_o) + 4'h1;
    endsequence
    chk_step_up: assert property (esc |=> s_step_up)
        else $error("range step missing");
    chk_done_set: assert property (fin |=> cfg_rdata_o[7])
        else $error("done flag not set");
    chk_read_clear: assert property (cfg_rd_i && !taken |=> !cfg_rdata_o[7])
        else $error("read left done set");
    chk_write_clear: assert property (cfg_wr_i && !shut && !taken |=> !cfg_rdata_o[7])
        else $error("write left done set");
    chk_shut_keep: assert property (cfg_wr_i && shut && !cfg_rd_i && !taken |=>
        $stable(cfg_rdata_o[7:5]) && $stable(alert_oe_b_o)) else $error("shutdown changed status");
    chk_above_now: assert property (fin && quiet && cfg_rdata_o[4] == 1'b0 &&
        cfg_rdata_o[1:0] == 2'h0 |=> cfg_rdata_o[6] == $past(hi_hit)) else $error("above flag off");
    chk_alert_sense: assert property (fin && quiet |=>
        alert_oe_b_o == ((cfg_rdata_o[6] || cfg_rdata_o[5]) == cfg_rdata_o[3]))
        else $error("alert pin wrong");
    chk_mask_exp: assert property (fin && quiet && cfg_rdata_o[2] && cfg_rdata_o[15:12] < 4'hc
        |=> result_o[15:12] == 4'h0) else $error("exponent not masked");
endmodule
bind light_sensor_status_irq light_sensor_status_irq_props u_props (.clk_i(clk_i),
    .rst_b_i(rst_b_i), .cfg_wr_i(cfg_wr_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rd_i(cfg_rd_i),
    .meas_i(meas_i), .high_limit_i(high_limit_i), .cfg_rdata_o(cfg_rdata_o),
    .conv_run_o(conv_run_o), .conv_range_o(conv_range_o), .conv_restart_o(conv_restart_o),
    .result_o(result_o), .alert_oe_b_o(alert_oe_b_o));
`default_nettype wire

// ---- test/light_sensor_status_irq_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module light_sensor_status_irq_tb;
    // Row: config, light, spike, result, {overload, done, above, below}, pin enable
    typedef struct packed {
        logic [15:0] cfg;
        logic [22:0] lux;
        logic spike;
        logic [15:0] res;
        logic [3:0] stat;
        logic oe_b;
    } row_s;
    localparam row_s ROWS [5] = '{{16'h0400, 23'h000258, 1'b0, 16'h0258, 4'h6, 1'b0},
        {16'h0408, 23'h000258, 1'b0, 16'h0258, 4'h6, 1'b1},
        {16'h0400, 23'h000064, 1'b0, 16'h0064, 4'h5, 1'b0},
        {16'h1404, 23'h0000c8, 1'b1, 16'h0064, 4'hc, 1'b1},
        {16'h2400, 23'h0007d0, 1'b0, 16'h21f4, 4'h6, 1'b0}};
    logic clk_i = 1'b0, rst_b_i = 1'b0, cfg_wr_i = 1'b0, cfg_rd_i = 1'b0, go = 1'b0, spike = 1'b0;
    logic [22:0] lux = 23'h000000;
    logic [15:0] cfg_wdata_i = 16'h0000, cfg_rdata_o, result_o;
    logic [3:0] conv_range_o;
    logic conv_run_o, conv_restart_o, alert_oe_b_o, conv_long_o, alert_o;
    light_sensor_pkg::meas_s meas;
    int errors = 0, cmp_count = 0, cyc = 0;
    // Clock
    always #12.5 clk_i = ~clk_i;
    light_converter_model u_model (.clk_i(clk_i), .go_i(go), .spike_i(spike), .lux_i(lux),
        .range_i(conv_range_o), .meas_o(meas));
    light_sensor_status_irq u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .cfg_wr_i(cfg_wr_i),
        .cfg_wdata_i(cfg_wdata_i), .cfg_rd_i(cfg_rd_i), .cfg_rdata_o(cfg_rdata_o), .meas_i(meas),
        .low_limit_i(16'h0080), .high_limit_i(16'h1100), .conv_run_o(conv_run_o),
        .conv_long_o(conv_long_o),
        .conv_range_o(conv_range_o), .conv_restart_o(conv_restart_o), .result_o(result_o),
        .alert_o(alert_o), .alert_oe_b_o(alert_oe_b_o));
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One-cycle write or clearing read
    task automatic access(input logic wr, input logic [15:0] data);
        @(posedge clk_i);
        cfg_wr_i <= wr;
        cfg_rd_i <= !wr;
        cfg_wdata_i <= data;
        @(posedge clk_i);
        cfg_wr_i <= 1'b0;
        cfg_rd_i <= 1'b0;
        #1;
    endtask
    // One conversion, checked once the block has taken it
    task automatic measure(input logic [22:0] l, input logic s);
        @(posedge clk_i);
        go <= 1'b1;
        lux <= l;
        spike <= s;
        @(posedge clk_i);
        go <= 1'b0;
        @(posedge clk_i);
        #1;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            errors++;
            tally_and_finish();
        end
    end
    // Main sequence
    initial begin
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        #1;
        chk("reset image", 16'hc810, cfg_rdata_o);
        chk("long after reset", 16'h0001, 16'(conv_long_o));
        chk("alert data", 16'h0000, 16'(alert_o));
        for (int i = 0; i < 5; i++) begin
            access(1'b1, ROWS[i].cfg);
            measure(ROWS[i].lux, ROWS[i].spike);
            chk("status", 16'(ROWS[i].stat), 16'(cfg_rdata_o[8:5]));
            chk("result", ROWS[i].res, result_o);
            chk("pin", 16'(ROWS[i].oe_b), 16'(alert_oe_b_o));
        end
        access(1'b1, 16'h0000);
        chk("kept status", 16'h0006, 16'(cfg_rdata_o[8:5]));
        chk("kept pin", 16'h0000, 16'(alert_oe_b_o));
        chk("run stopped", 16'h0000, 16'(conv_run_o));
        access(1'b0, 16'h0000);
        chk("done cleared", 16'h0000, 16'(cfg_rdata_o[7]));
        // Latched, two faults needed, with a break in the run
        access(1'b1, 16'h0411);
        access(1'b0, 16'h0000);
        measure(23'h000064, 1'b0);
        measure(23'h00012c, 1'b0);
        measure(23'h000064, 1'b0);
        chk("below one", 16'h0000, 16'(cfg_rdata_o[5]));
        measure(23'h000064, 1'b0);
        chk("below two", 16'h0001, 16'(cfg_rdata_o[5]));
        measure(23'h00012c, 1'b0);
        chk("below held", 16'h0001, 16'(cfg_rdata_o[5]));
        access(1'b0, 16'h0000);
        chk("below cleared", 16'h0000, 16'(cfg_rdata_o[5]));
        // Automatic range: one step, then up to the top range
        access(1'b1, 16'hc400);
        measure(23'h001388, 1'b0);
        chk("restart", 16'h0011, {11'h000, conv_restart_o, conv_range_o});
        chk("done held", 16'h0000, 16'(cfg_rdata_o[7]));
        measure(23'h001388, 1'b0);
        chk("auto result", 16'h19c4, result_o);
        for (int i = 0; i < 12; i++) begin
            measure(23'h000064, 1'b1);
        end
        chk("top range", 16'h001b, {11'h000, cfg_rdata_o[8], result_o[15:12]});
        // Single shot: runs once, then falls back to shutdown
        access(1'b1, 16'h0200);
        chk("single run", 16'h0001, 16'(conv_run_o));
        measure(23'h000064, 1'b0);
        chk("single stop", 16'h0000, 16'(conv_run_o));
        chk("single done", 16'h0001, 16'(cfg_rdata_o[7]));
        tally_and_finish();
    end
endmodule
`default_nettype wire
